// [design/gpm_pkg.sv]
// constants, register map and field layout of the gpio, pin interrupt and pattern match block
// Operation
// RQ1 - two ports of 32 pins each, 64 pins driven from port registers
// RQ2 - every port bit has its own direction bit, changeable at run time
// RQ3 - set and clear locations change only the bits written as one
// RQ4 - pin reads return the synchronised pad level whatever function the pin has
// RQ5 - mask register hides masked bits from masked reads and masked writes
// RQ6 - byte and half-word writes update only the addressed byte lanes
// RQ7 - one write to the pin location loads a whole port output word
// RQ8 - toggle location inverts every output bit written as one
// RQ9 - all pins are inputs after reset
// RQ10 - two group interrupts, each from a programmable combination of pins
// RQ11 - group interrupts request wake-up in sleep, deep-sleep and power-down
// RQ12 - eight selectable pin interrupts, each on its own output line
// RQ13 - edge mode triggers on rising, falling or both edges as enabled
// RQ14 - level mode requests while the pin matches the programmed polarity
// RQ15 - pin interrupts request wake-up in sleep and deep-sleep
// RQ16 - any of the 64 pins can feed a pin interrupt or pattern slice
// RQ17 - pattern engine ands level or edge conditions of eight slices into terms
// RQ18 - each product term raises its own interrupt line when matched
// RQ19 - a new match optionally pulses the cpu event notify output
// RQ20 - pattern matches request wake-up only in active or sleep; the code requests it in sleep only
// RQ21 - in power-down pins read as zero and outputs drive zero
// RQ22 - in deep power-down all pins are released to high impedance
// RQ23 - pad inputs pass two flip-flops before any edge or level logic
package gpm_pkg;
  localparam int unsigned GPM_NPIN = 64;
  localparam int unsigned GPM_PW = 32;
  localparam int unsigned GPM_NCH = 8;
  localparam int unsigned GPM_NGRP = 2;
  // port registers: port p at byte address p * 0x40, offset below
  localparam logic [5:0] GPM_P_DIR = 6'h00;
  localparam logic [5:0] GPM_P_MASK = 6'h04;
  localparam logic [5:0] GPM_P_PIN = 6'h08;
  localparam logic [5:0] GPM_P_MPIN = 6'h0c;
  localparam logic [5:0] GPM_P_SET = 6'h10;
  localparam logic [5:0] GPM_P_CLR = 6'h14;
  localparam logic [5:0] GPM_P_NOT = 6'h18;
  // pin interrupt and pattern engine registers
  localparam logic [11:0] GPM_PSEL0 = 12'h100;
  localparam logic [11:0] GPM_PSEL1 = 12'h104;
  localparam logic [11:0] GPM_ISEL = 12'h108;
  localparam logic [11:0] GPM_IENR = 12'h10c;
  localparam logic [11:0] GPM_IENF = 12'h110;
  localparam logic [11:0] GPM_RISE = 12'h114;
  localparam logic [11:0] GPM_FALL = 12'h118;
  localparam logic [11:0] GPM_IST = 12'h11c;
  localparam logic [11:0] GPM_PMCTRL = 12'h120;
  localparam logic [11:0] GPM_PMSRC = 12'h124;
  localparam logic [11:0] GPM_PMCFG = 12'h128;
  // group g at byte address 0x140 + g * 0x20, offset below
  localparam logic [5:0] GPM_GRP_PAGE = 6'h05;
  localparam logic [4:0] GPM_G_CTRL = 5'h00;
  localparam logic [4:0] GPM_G_POL0 = 5'h04;
  localparam logic [4:0] GPM_G_POL1 = 5'h08;
  localparam logic [4:0] GPM_G_ENA0 = 5'h0c;
  localparam logic [4:0] GPM_G_ENA1 = 5'h10;
  // field positions
  localparam int unsigned GPM_PSEL_STRIDE = 8;
  localparam int unsigned GPM_PMCTRL_MODE = 0;
  localparam int unsigned GPM_PMCTRL_EVEN = 1;
  localparam int unsigned GPM_GCTRL_FLAG = 0;
  localparam int unsigned GPM_GCTRL_COMB = 1;
  localparam int unsigned GPM_GCTRL_TRIG = 2;
  // slice conditions
  localparam logic [2:0] GPM_PC_ONE = 3'h0;
  localparam logic [2:0] GPM_PC_RISE = 3'h1;
  localparam logic [2:0] GPM_PC_FALL = 3'h2;
  localparam logic [2:0] GPM_PC_EDGE = 3'h3;
  localparam logic [2:0] GPM_PC_HIGH = 3'h4;
  localparam logic [2:0] GPM_PC_LOW = 3'h5;
  localparam logic [2:0] GPM_PC_ZERO = 3'h6;
  localparam logic [2:0] GPM_PC_EVT = 3'h7;
  // power modes on the power mode input
  localparam logic [2:0] GPM_PM_ACT = 3'h0;
  localparam logic [2:0] GPM_PM_SLEEP = 3'h1;
  localparam logic [2:0] GPM_PM_DSLEEP = 3'h2;
  localparam logic [2:0] GPM_PM_PDOWN = 3'h3;
  localparam logic [2:0] GPM_PM_DPD = 3'h4;
  // reset values and the read-as-zero value
  localparam logic [63:0] GPM_DIR_RST = 64'h0;
  localparam logic [63:0] GPM_OUT_RST = 64'h0;
  localparam logic [31:0] GPM_RD_ZERO = 32'h0;
endpackage : gpm_pkg

// [design/gpm_top.sv]
// gpio ports with pin interrupts, group interrupts and pattern match engine behind apb
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
module gpm_top
  import gpm_pkg::*;
#(
  parameter int unsigned N_CH = GPM_NCH
)
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  input wire logic [63:0] PAD_IN_I,
  output logic [63:0] PAD_OUT_O,
  output logic [63:0] PAD_OE_N_O,
  input wire logic [2:0] PWR_MODE_I,
  output logic [7:0] PIN_IRQ_O,
  output logic [1:0] GRP_IRQ_O,
  output logic CPU_EVENT_NOTIFY_O,
  output logic WAKE_O
);

  if (N_CH != GPM_NCH)
  begin : g_chk
    $error("gpm_top: channel count must be 8");
  end

  typedef struct packed {
    logic [63:0] sync1;
    logic [63:0] sync2;
    logic [63:0] dir;
    logic [63:0] mask;
    logic [63:0] outv;
    logic [63:0] pad_out;
    logic [63:0] pad_oe_n;
    logic [1:0][63:0] gpol;
    logic [1:0][63:0] gena;
    logic [7:0][5:0] psel;
    logic [7:0] isel;
    logic [7:0] ienr;
    logic [7:0] ienf;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] ch_prev;
    logic [7:0] pin_irq;
    logic pmode;
    logic evena;
    logic [7:0][2:0] pmsrc;
    logic [7:0][2:0] pmcond;
    logic [7:0] pmend;
    logic [7:0] pm_rs;
    logic [7:0] pm_fs;
    logic [7:0] match;
    logic [1:0] gcomb;
    logic [1:0] gtrig;
    logic [1:0] gflag;
    logic [1:0] gprev;
    logic [1:0] grp_irq;
    logic pready;
    logic pslverr;
    logic evt;
    logic wake;
    logic [31:0] prdata;
  } gpm_state_t;

  gpm_state_t q;
  gpm_state_t n;

  function automatic logic [31:0] gpm_lanes(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0;
    for (int k = 0; k < 4; k++)
    begin
      m[8*k +: 8] = {8{s[k]}};
    end
    return m;
  endfunction : gpm_lanes

  function automatic logic [31:0] gpm_merge(input logic [31:0] o, input logic [31:0] v,
                                            input logic [31:0] lm);
    return (o & ~lm) | (v & lm);
  endfunction : gpm_merge

  // rs/fs already include an edge seen this cycle
  function automatic logic gpm_cond(input logic [2:0] c, input logic v, input logic rs,
                                    input logic fs, input logic re, input logic fe);
    logic r;
    case (c)
      GPM_PC_ONE: r = 1'b1;
      GPM_PC_RISE: r = rs;
      GPM_PC_FALL: r = fs;
      GPM_PC_EDGE: r = rs | fs;
      GPM_PC_HIGH: r = v;
      GPM_PC_LOW: r = ~v;
      GPM_PC_ZERO: r = 1'b0;
      GPM_PC_EVT: r = re | fe;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : gpm_cond

  logic pd;
  logic dpd;
  logic slp;
  logic dslp;
  logic [63:0] pad_rd;
  logic [7:0] chv;
  logic [7:0] ch_re;
  logic [7:0] ch_fe;
  logic [7:0] sl_v;
  logic [7:0] sl_re;
  logic [7:0] sl_fe;
  logic [7:0] mt;
  logic [7:0] pm_clr;
  logic [7:0] slices;
  logic term;
  logic acc;
  logic wr;
  logic hit;
  logic [31:0] lm;
  logic [31:0] rd;
  logic [31:0] wd;
  logic is_port;
  logic pidx;
  logic [5:0] po;
  logic is_grp;
  logic gi;
  logic [4:0] go;
  logic [31:0] h_dir;
  logic [31:0] h_mask;
  logic [31:0] h_out;
  logic [31:0] h_pad;
  logic [31:0] v32;
  logic [7:0] rise_clr;
  logic [7:0] fall_clr;
  logic [1:0] g_clr;
  logic [63:0] g_act;
  logic g_hit;

  always_comb
  begin
    n = q;
    // the first stage feeds only the second
    n.sync1 = PAD_IN_I;
    n.sync2 = q.sync1; // see RQ23
    pd = (PWR_MODE_I == GPM_PM_PDOWN);
    dpd = (PWR_MODE_I == GPM_PM_DPD);
    slp = (PWR_MODE_I == GPM_PM_SLEEP);
    dslp = (PWR_MODE_I == GPM_PM_DSLEEP);
    pad_rd = pd ? 64'h0 : q.sync2; // see RQ4, see RQ21

    // channel inputs from any pin, ignoring the pin function
    for (int i = 0; i < 8; i++)
    begin
      chv[i] = pad_rd[q.psel[i]]; // see RQ16
    end
    ch_re = chv & ~q.ch_prev;
    ch_fe = ~chv & q.ch_prev;
    n.ch_prev = chv;

    // apb decode; the answer comes one cycle into the access phase
    acc = PSEL_I & PENABLE_I;
    wr = acc & q.pready & PWRITE_I;
    n.pready = acc & ~q.pready;
    lm = gpm_lanes(PSTRB_I);
    wd = PWDATA_I;
    is_port = (PADDR_I[11:7] == 5'h00);
    pidx = PADDR_I[6];
    po = PADDR_I[5:0];
    is_grp = (PADDR_I[11:6] == GPM_GRP_PAGE);
    gi = PADDR_I[5];
    go = PADDR_I[4:0];
    h_dir = pidx ? q.dir[63:32] : q.dir[31:0];
    h_mask = pidx ? q.mask[63:32] : q.mask[31:0];
    h_out = pidx ? q.outv[63:32] : q.outv[31:0];
    h_pad = pidx ? pad_rd[63:32] : pad_rd[31:0];
    rd = GPM_RD_ZERO;
    hit = 1'b1;
    rise_clr = 8'h00;
    fall_clr = 8'h00;
    g_clr = 2'b00;
    v32 = 32'h0;
    g_hit = 1'b0;

    if (is_port)
    begin
      case (po)
        GPM_P_DIR:
        begin
          rd = h_dir;
          h_dir = gpm_merge(h_dir, wd, lm); // see RQ2, see RQ6
        end
        GPM_P_MASK:
        begin
          rd = h_mask;
          h_mask = gpm_merge(h_mask, wd, lm);
        end
        GPM_P_PIN:
        begin
          rd = h_pad;
          h_out = gpm_merge(h_out, wd, lm); // see RQ7
        end
        GPM_P_MPIN:
        begin
          rd = h_pad & ~h_mask;
          h_out = gpm_merge(h_out, wd, lm & ~h_mask); // see RQ5
        end
        GPM_P_SET:
        begin
          rd = h_out;
          h_out = h_out | (wd & lm); // see RQ3
        end
        GPM_P_CLR: h_out = h_out & ~(wd & lm); // see RQ3
        GPM_P_NOT: h_out = h_out ^ (wd & lm); // see RQ8
        default: hit = 1'b0;
      endcase
      if (wr)
      begin
        if (pidx)
        begin
          n.dir[63:32] = h_dir;
          n.mask[63:32] = h_mask;
          n.outv[63:32] = h_out;
        end
        else
        begin
          n.dir[31:0] = h_dir;
          n.mask[31:0] = h_mask;
          n.outv[31:0] = h_out;
        end
      end
    end
    else if (is_grp)
    begin
      g_hit = 1'b1;
      case (go)
        GPM_G_CTRL: rd = {29'h0, q.gtrig[gi], q.gcomb[gi], q.gflag[gi]};
        GPM_G_POL0: rd = q.gpol[gi][31:0];
        GPM_G_POL1: rd = q.gpol[gi][63:32];
        GPM_G_ENA0: rd = q.gena[gi][31:0];
        GPM_G_ENA1: rd = q.gena[gi][63:32];
        default: g_hit = 1'b0;
      endcase
      hit = g_hit;
      if (wr)
      begin
        case (go)
          GPM_G_CTRL:
          begin
            if (lm[0])
            begin
              g_clr[gi] = wd[GPM_GCTRL_FLAG];
              n.gcomb[gi] = wd[GPM_GCTRL_COMB];
              n.gtrig[gi] = wd[GPM_GCTRL_TRIG];
            end
          end
          GPM_G_POL0: n.gpol[gi][31:0] = gpm_merge(rd, wd, lm);
          GPM_G_POL1: n.gpol[gi][63:32] = gpm_merge(rd, wd, lm);
          GPM_G_ENA0: n.gena[gi][31:0] = gpm_merge(rd, wd, lm);
          GPM_G_ENA1: n.gena[gi][63:32] = gpm_merge(rd, wd, lm);
          default: g_clr = 2'b00;
        endcase
      end
    end
    else
    begin
      case (PADDR_I)
        GPM_PSEL0, GPM_PSEL1:
        begin
          for (int k = 0; k < 4; k++)
          begin
            rd[8*k +: 6] = q.psel[{PADDR_I[2], 2'(k)}];
          end
          v32 = gpm_merge(rd, wd, lm);
          if (wr)
          begin
            for (int k = 0; k < 4; k++)
            begin
              n.psel[{PADDR_I[2], 2'(k)}] = v32[8*k +: 6];
            end
          end
        end
        GPM_ISEL:
        begin
          rd = {24'h0, q.isel};
          if (wr && lm[0]) n.isel = wd[7:0];
        end
        GPM_IENR:
        begin
          rd = {24'h0, q.ienr};
          if (wr && lm[0]) n.ienr = wd[7:0];
        end
        GPM_IENF:
        begin
          rd = {24'h0, q.ienf};
          if (wr && lm[0]) n.ienf = wd[7:0];
        end
        GPM_RISE:
        begin
          rd = {24'h0, q.rise};
          if (wr) rise_clr = wd[7:0] & lm[7:0];
        end
        GPM_FALL:
        begin
          rd = {24'h0, q.fall};
          if (wr) fall_clr = wd[7:0] & lm[7:0];
        end
        GPM_IST: rd = {24'h0, q.pin_irq};
        GPM_PMCTRL:
        begin
          rd = {q.match, 22'h0, q.evena, q.pmode};
          if (wr && lm[0])
          begin
            n.pmode = wd[GPM_PMCTRL_MODE];
            n.evena = wd[GPM_PMCTRL_EVEN];
          end
        end
        GPM_PMSRC:
        begin
          rd = {8'h0, q.pmsrc};
          v32 = gpm_merge(rd, wd, lm);
          if (wr) n.pmsrc = v32[23:0];
        end
        GPM_PMCFG:
        begin
          rd = {q.pmcond, q.pmend};
          v32 = gpm_merge(rd, wd, lm);
          if (wr)
          begin
            n.pmcond = v32[31:8];
            n.pmend = v32[7:0];
          end
        end
        default: hit = 1'b0;
      endcase
    end
    if (n.pready)
    begin
      n.prdata = hit ? rd : GPM_RD_ZERO;
      n.pslverr = ~hit;
    end

    // pin interrupts; a hardware set in the clearing cycle wins
    n.rise = (q.rise & ~rise_clr) | (ch_re & q.ienr & ~q.isel); // see RQ13
    n.fall = (q.fall & ~fall_clr) | (ch_fe & q.ienf & ~q.isel); // see RQ13

    // pattern slices, each taking one of the eight channels
    for (int i = 0; i < 8; i++)
    begin
      sl_v[i] = chv[q.pmsrc[i]];
      sl_re[i] = ch_re[q.pmsrc[i]];
      sl_fe[i] = ch_fe[q.pmsrc[i]];
    end
    term = 1'b1;
    slices = 8'h00;
    pm_clr = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      term = term & gpm_cond(q.pmcond[i], sl_v[i], q.pm_rs[i] | sl_re[i],
                             q.pm_fs[i] | sl_fe[i], sl_re[i], sl_fe[i]); // see RQ17
      slices[i] = 1'b1;
      mt[i] = q.pmend[i] & term;
      if (q.pmend[i])
      begin
        if (term) pm_clr = pm_clr | slices;
        term = 1'b1;
        slices = 8'h00;
      end
    end
    // a matched term consumes its sticky edges so the next match needs new edges
    if (!q.pmode) pm_clr = 8'hff;
    n.pm_rs = (q.pm_rs | sl_re) & ~pm_clr;
    n.pm_fs = (q.pm_fs | sl_fe) & ~pm_clr;
    n.match = q.pmode ? mt : 8'h00;
    n.evt = q.pmode & q.evena & (|(mt & ~q.match)); // see RQ19

    for (int i = 0; i < 8; i++)
    begin
      if (q.pmode)
        n.pin_irq[i] = mt[i]; // see RQ18
      else if (q.isel[i])
        n.pin_irq[i] = q.ienr[i] & ~(chv[i] ^ q.ienf[i]); // see RQ14
      else
        n.pin_irq[i] = n.rise[i] | n.fall[i]; // see RQ12
    end

    // group interrupts: and/or of enabled pins matching their polarity
    for (int g = 0; g < 2; g++)
    begin
      // groups watch the real pad levels, so the zeroed power-down read view cannot hide a wake
      g_act = q.gena[g] & ~(q.sync2 ^ q.gpol[g]);
      term = q.gcomb[g] ? ((g_act == q.gena[g]) && (|q.gena[g])) : (|g_act); // see RQ10
      n.gprev[g] = term;
      n.gflag[g] = (q.gflag[g] & ~g_clr[g]) | (q.gtrig[g] ? term : (term & ~q.gprev[g]));
      n.grp_irq[g] = q.gtrig[g] ? term : n.gflag[g];
    end

    // wake requests only from the modes each source supports
    n.wake = ((|n.grp_irq) & (slp | dslp | pd)) // see RQ11
           | (~q.pmode & (|n.pin_irq) & (slp | dslp)) // see RQ15
           | (q.pmode & (|n.pin_irq) & slp); // see RQ20

    n.pad_out = pd ? 64'h0 : q.outv; // see RQ21
    // deep power-down releases every pin regardless of direction
    n.pad_oe_n = dpd ? {64{1'b1}} : ~q.dir; // see RQ22, see RQ1
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      q <= '0;
      q.dir <= GPM_DIR_RST; // see RQ9
      q.outv <= GPM_OUT_RST;
      q.pad_oe_n <= ~GPM_DIR_RST; // see RQ9
    end
    else
    begin
      q <= n;
    end
  end

  assign PREADY_O = q.pready;
  assign PRDATA_O = q.prdata;
  assign PSLVERR_O = q.pslverr;
  assign PAD_OUT_O = q.pad_out;
  assign PAD_OE_N_O = q.pad_oe_n;
  assign PIN_IRQ_O = q.pin_irq;
  assign GRP_IRQ_O = q.grp_irq;
  assign CPU_EVENT_NOTIFY_O = q.evt;
  assign WAKE_O = q.wake;

endmodule : gpm_top

// [tb/gpm_sva.sv]
// port assertions for the gpio, pin interrupt and pattern block
`timescale 1ns/100ps
module gpm_sva
  import gpm_pkg::*;
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic [63:0] PAD_OUT_O,
  input wire logic [63:0] PAD_OE_N_O,
  input wire logic [2:0] PWR_MODE_I,
  input wire logic CPU_EVENT_NOTIFY_O,
  input wire logic WAKE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  property p_ready_wait;
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready missing after wait state");
  property p_ready_pulse;
    PREADY_O |=> !PREADY_O;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_ready_cause;
    PREADY_O |-> $past(PSEL_I && PENABLE_I);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  // read data must not wander between answers, software may sample late
  property p_rdata_hold;
    !PREADY_O |-> $stable(PRDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_oe_reset;
    $rose(ARST_N_I) |-> PAD_OE_N_O == 64'hffff_ffff_ffff_ffff;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pins not inputs after reset");
  property p_pdown_zero;
    (PWR_MODE_I == GPM_PM_PDOWN) [*3] |-> PAD_OUT_O == 64'h0;
  endproperty
  a_pdown_zero: assert property (p_pdown_zero) else $error("pins driven in power-down");
  property p_dpd_release;
    (PWR_MODE_I == GPM_PM_DPD) [*3] |-> PAD_OE_N_O == 64'hffff_ffff_ffff_ffff && !WAKE_O;
  endproperty
  a_dpd_release: assert property (p_dpd_release) else $error("pins held in deep power-down");
  property p_event_pulse;
    CPU_EVENT_NOTIFY_O |=> !CPU_EVENT_NOTIFY_O;
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event longer than one cycle");
  c_event: cover property (CPU_EVENT_NOTIFY_O);
  c_wake: cover property (WAKE_O);
  c_dpd: cover property (PWR_MODE_I == GPM_PM_DPD);
endmodule : gpm_sva
bind gpm_top gpm_sva u_sva(.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PAD_OUT_O(PAD_OUT_O),
  .PAD_OE_N_O(PAD_OE_N_O), .PWR_MODE_I(PWR_MODE_I), .CPU_EVENT_NOTIFY_O(CPU_EVENT_NOTIFY_O),
  .WAKE_O(WAKE_O));

// [tb/gpm_pad_model.sv]
// external pads: each line shows the device level where driven, else the outside level
`timescale 1ns/100ps
module gpm_pad_model
(
  input wire logic [63:0] pad_out_i,
  input wire logic [63:0] pad_oe_n_i,
  input wire logic [63:0] ext_lvl_i,
  output logic [63:0] pad_in_o
);
  // the pad is read back whatever drives it, so driven outputs echo here
  assign pad_in_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_lvl_i);
endmodule : gpm_pad_model

// [tb/tb_top.sv]
// self-checking bench for the gpio, pin interrupt and pattern block
`timescale 1ns/100ps
module tb_top
  import gpm_pkg::*;
;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, evt, wake, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] pwr_mode;
  logic [63:0] ext_lvl, pad_in, pad_out, pad_oe_n;
  logic [7:0] pin_irq;
  logic [1:0] grp_irq;
  int fails, total_checks, evt_cnt;
  gpm_top u_dut(.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready),
    .PRDATA_O(prdata), .PSLVERR_O(pslverr), .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out),
    .PAD_OE_N_O(pad_oe_n), .PWR_MODE_I(pwr_mode), .PIN_IRQ_O(pin_irq), .GRP_IRQ_O(grp_irq),
    .CPU_EVENT_NOTIFY_O(evt), .WAKE_O(wake));
  gpm_pad_model u_pads(.pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n), .ext_lvl_i(ext_lvl),
    .pad_in_o(pad_in));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (evt === 1'b1)
      evt_cnt <= evt_cnt + 1;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // pready is sampled at the rising edge that ends the access, as the master sees it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      $display("mismatch pready expected 1 seen 0");
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, {32'h0, exp}, {32'h0, rd});
  endtask : rdc
  task automatic setx(input int i, input logic v);
    @(posedge clk);
    ext_lvl[i] <= v;
    repeat (8) @(posedge clk);
  endtask : setx
  task automatic setpm(input logic [2:0] m);
    @(posedge clk);
    pwr_mode <= m;
    repeat (6) @(posedge clk);
  endtask : setpm
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    pwr_mode = GPM_PM_ACT;
    ext_lvl = 64'ha5a5_5a5a_0f0f_f0f0;
    {fails, total_checks} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    chk("oe_reset", 64'hffff_ffff_ffff_ffff, pad_oe_n);
    rdc("dir_reset", {6'h00, GPM_P_DIR}, 32'h0);
    $display("test reset done");
    wr({6'h00, GPM_P_DIR}, 32'h0000_ffff);
    wr({6'h00, GPM_P_PIN}, 32'h1234_abcd);
    repeat (6) @(posedge clk);
    chk("oe_port0", 64'hffff_ffff_ffff_0000, pad_oe_n);
    rdc("out_full", {6'h00, GPM_P_SET}, 32'h1234_abcd);
    rdc("pads0", {6'h00, GPM_P_PIN}, 32'h0f0f_abcd);
    wr({6'h00, GPM_P_SET}, 32'h0000_0003);
    wr({6'h00, GPM_P_CLR}, 32'h000f_0000);
    rdc("set_clr", {6'h00, GPM_P_SET}, 32'h1230_abcf);
    wr({6'h00, GPM_P_NOT}, 32'hff00_0000);
    rdc("toggle", {6'h00, GPM_P_SET}, 32'hed30_abcf);
    apb(1'b1, {6'h00, GPM_P_PIN}, 32'h0000_5500, 4'b0010);
    rdc("byte_lane", {6'h00, GPM_P_SET}, 32'hed30_55cf);
    wr({6'h00, GPM_P_MASK}, 32'hffff_0000);
    wr({6'h00, GPM_P_MPIN}, 32'hffff_ffff);
    rdc("mask_wr", {6'h00, GPM_P_SET}, 32'hed30_ffff);
    repeat (4) @(posedge clk);
    rdc("mask_rd", {6'h00, GPM_P_MPIN}, 32'h0000_ffff);
    wr({6'h00, GPM_P_MASK}, 32'h0);
    wr({6'h01, GPM_P_DIR}, 32'hffff_ffff);
    wr({6'h01, GPM_P_PIN}, 32'hdead_beef);
    repeat (4) @(posedge clk);
    chk("port1_out", 64'hdead_beef_ed30_ffff, pad_out);
    apb(1'b0, 12'hffc, 32'h0, 4'h0);
    chk("unmapped", {32'h1, 32'h0}, {31'h0, er, rd});
    $display("test port done");
    wr(GPM_PSEL0, 32'h0000_1514);
    wr(GPM_ISEL, 32'h1);
    wr(GPM_IENR, 32'h3);
    wr(GPM_IENF, 32'h3);
    @(posedge clk);
    ext_lvl[20] <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sync_delay", 64'h0, {63'h0, pin_irq[0]});
    repeat (5) @(posedge clk);
    chk("level_hi", 64'h1, {63'h0, pin_irq[0]});
    setx(20, 1'b0);
    chk("level_off", 64'h0, {63'h0, pin_irq[0]});
    setx(21, 1'b1);
    chk("rise", 64'h1, {63'h0, pin_irq[1]});
    chk("irq_lines", 64'h02, {56'h0, pin_irq});
    wr(GPM_RISE, 32'h2);
    repeat (3) @(posedge clk);
    chk("rise_clr", 64'h0, {63'h0, pin_irq[1]});
    setx(21, 1'b0);
    chk("fall", 64'h1, {63'h0, pin_irq[1]});
    wr(GPM_FALL, 32'h2);
    wr(GPM_IENF, 32'h2);
    repeat (4) @(posedge clk);
    chk("level_lo", 64'h1, {63'h0, pin_irq[0]});
    $display("test pin irq done");
    wr(12'h14c, 32'h0040_0000);
    wr(12'h144, 32'h0040_0000);
    wr(12'h140, 32'h4);
    setx(22, 1'b1);
    chk("group", 64'h1, {63'h0, grp_irq[0]});
    setpm(GPM_PM_PDOWN);
    chk("wake_pd", 64'h1, {63'h0, wake});
    rdc("pd_read", {6'h00, GPM_P_PIN}, 32'h0);
    setpm(GPM_PM_DPD);
    chk("dpd_oe", 64'hffff_ffff_ffff_ffff, pad_oe_n);
    setpm(GPM_PM_ACT);
    chk("oe_back", 64'h0000_0000_ffff_0000, pad_oe_n);
    wr(12'h14c, 32'h0);
    setpm(GPM_PM_DSLEEP);
    chk("wake_ds", 64'h1, {63'h0, wake});
    setpm(GPM_PM_ACT);
    $display("test power done");
    wr(GPM_IENF, 32'h3);
    wr(GPM_PMSRC, 32'h0);
    wr(GPM_PMCFG, 32'h0000_0401);
    wr(GPM_PMCTRL, 32'h3);
    setx(20, 1'b1);
    chk("term0", 64'h1, {63'h0, pin_irq[0]});
    chk("event", 64'h1, 64'(evt_cnt));
    setpm(GPM_PM_DSLEEP);
    chk("pm_wake_ds", 64'h0, {63'h0, wake});
    setpm(GPM_PM_SLEEP);
    chk("pm_wake_sl", 64'h1, {63'h0, wake});
    $display("test pattern done");
    complete_run();
  end
endmodule : tb_top
